// ===== logic/tswt_device.sv
`default_nettype none
// Summary of operation
// - Enabled 32-bit counter decrements, zero is time-out
// - Enabling counter also enables non-maskable interrupt
// - After first time-out reload and keep counting
// - Second zero with interrupt pending asserts reset
// - Cleared interrupt: reload and resume, no reset
// - Load write while counting loads counter immediately
// - Non-zero load write leaves pending interrupt unchanged
// - Only interrupt clear write clears interrupt
// - Interrupt and reset separately enabled, reset additional
// - Enabling interrupt preloads counter from load value
// - Interrupt enable starts watchdog, locks control
// - Any lock write except the key locks load, control and clear
// - Only the key value unlocks registers
// - Software order: load, reset enable, interrupt enable
// - Software enables peripheral clock before any access
// - Writing zero load raises interrupt at once
// - Control writes ignored after enable until reset
// - Clear write clears interrupt and reloads counter
module tswt_device
  import tswt_pkg::*;
#(
  parameter int CNT_W = WDT_CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link to the controller
  tswt_link_if.device link,
  // Observation
  output logic [31:0] countValue,
  output logic timeoutPulse
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (CNT_W < 2 || CNT_W > 32) begin : gBadWidth
    $error("tswt_device: CNT_W must lie in 2..32");
  end

  // ****************************************
  // State
  // ****************************************
  logic [CNT_W-1:0] loadReg;
  logic [CNT_W-1:0] countReg;
  logic intEnReg;
  logic resEnReg;
  logic risReg;
  logic lockedReg;
  logic sysResetReg;
  logic timeoutReg;
  logic [31:0] rdataReg;

  // ****************************************
  // Access decode
  // ****************************************
  logic wrLoad;
  logic wrCtl;
  logic wrIcr;
  logic wrLock;
  logic intEnSet;
  logic running;
  logic reloadNow;
  logic timeoutHit;
  logic zeroLoad;
  logic [CNT_W-1:0] wdataCnt;

  assign wdataCnt = link.regWdata[CNT_W-1:0];
  // Lock register stays writable, otherwise nothing could unlock
  assign wrLock = link.regWr && link.regAddr == WDT_OFS_LOCK;
  assign wrLoad = link.regWr && link.regAddr == WDT_OFS_LOAD && !lockedReg;
  assign wrIcr = link.regWr && link.regAddr == WDT_OFS_ICR && !lockedReg;
  // Control writes die once the interrupt is enabled
  assign wrCtl = link.regWr && link.regAddr == WDT_OFS_CTL && !lockedReg
                 && !intEnReg;
  assign intEnSet = wrCtl && link.regWdata[WDT_CTL_INTERRUPT_ENABLE_BIT_BIT];
  assign zeroLoad = wrLoad && wdataCnt == '0;
  assign running = intEnReg && link.periphClkEn;
  assign reloadNow = wrLoad || wrIcr || intEnSet;
  assign timeoutHit = running && countReg == '0 && !reloadNow;

  // ****************************************
  // Lock
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lockedReg <= WDT_LOCK_RST;
    end else if (wrLock) begin
      lockedReg <= link.regWdata != WDT_UNLOCK_KEY;
    end
  end

  // ****************************************
  // Control
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intEnReg <= WDT_CTL_RST;
      resEnReg <= WDT_CTL_RST;
    end else if (wrCtl) begin
      intEnReg <= link.regWdata[WDT_CTL_INTERRUPT_ENABLE_BIT_BIT];
      resEnReg <= link.regWdata[WDT_CTL_RESET_OUTPUT_ENABLE_BIT];
    end
  end

  // ****************************************
  // Load value
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      loadReg <= WDT_LOAD_RST[CNT_W-1:0];
    end else if (wrLoad) begin
      loadReg <= wdataCnt;
    end
  end

  // ****************************************
  // Down counter
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      countReg <= WDT_LOAD_RST[CNT_W-1:0];
    end else if (wrLoad) begin
      countReg <= wdataCnt;
    end else if (wrIcr) begin
      countReg <= loadReg;
    end else if (intEnSet) begin
      countReg <= loadReg;
    end else if (running) begin
      if (countReg == '0) begin
        countReg <= loadReg;
      end else begin
        countReg <= countReg - 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // A zero count in the clearing cycle is no time-out: the clear wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      risReg <= WDT_RIS_RST;
    end else if (timeoutHit || zeroLoad) begin
      risReg <= 1'b1;
    end else if (wrIcr) begin
      risReg <= 1'b0;
    end
  end
  // A non-zero load write reaches none of the branches above
  // so the pending flag stays as it was.

  // ****************************************
  // System reset
  // ****************************************
  // Held until the hardware reset that it causes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sysResetReg <= 1'b0;
    end else if (timeoutHit && risReg && resEnReg) begin
      sysResetReg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timeoutReg <= 1'b0;
    end else begin
      timeoutReg <= timeoutHit;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Clear register reads as zero; its value is not defined
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdataReg <= 32'h0;
    end else if (link.regRd) begin
      unique case (link.regAddr)
        WDT_OFS_LOAD: rdataReg <= 32'(loadReg);
        WDT_OFS_VALUE: rdataReg <= 32'(countReg);
        WDT_OFS_CTL: rdataReg <= 32'({resEnReg, intEnReg});
        WDT_OFS_RIS: rdataReg <= 32'(risReg);
        WDT_OFS_MIS: rdataReg <= 32'(risReg && intEnReg);
        WDT_OFS_LOCK: rdataReg <= 32'(lockedReg);
        default: rdataReg <= 32'h0;
      endcase
    end else begin
      rdataReg <= 32'h0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.regRdata = rdataReg;
  assign link.nmiReq = risReg && intEnReg;
  assign link.sysResetReq = sysResetReg;
  assign countValue = 32'(countReg);
  assign timeoutPulse = timeoutReg;

endmodule : tswt_device
`default_nettype wire

// ===== logic/tswt_host.sv
`default_nettype none
module tswt_host
  import tswt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link to the watchdog
  tswt_link_if.host link,
  // Software register port
  input wire logic [4:0] swAddr,
  input wire logic [31:0] swWdata,
  input wire logic swWr,
  input wire logic swRd,
  output logic [31:0] swRdata,
  // Core side
  output logic irq,
  output logic coreNmi,
  output logic sysResetOut
);

  // ****************************************
  // State
  // ****************************************
  logic gateReg;
  logic [11:0] addrReg;
  logic [31:0] dataReg;
  logic [31:0] resultReg;
  logic [2:0] statReg;
  logic [2:0] maskReg;
  logic busWrReg;
  logic busRdReg;
  logic [11:0] busAddrReg;
  logic [31:0] busWdataReg;
  logic rdPendReg;
  logic nmiPrevReg;
  logic rstPrevReg;
  logic nmiReg;
  logic sysRstReg;
  logic [31:0] swRdataReg;

  logic goWr;
  logic [2:0] events;
  logic [2:0] clrBits;

  assign goWr = swWr && swAddr == HST_OFS_GO;

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gateReg <= 1'b0;
      addrReg <= 12'h0;
      dataReg <= 32'h0;
      maskReg <= HST_STAT_RST_VAL;
    end else if (swWr) begin
      if (swAddr == HST_OFS_GATE) begin
        gateReg <= swWdata[HST_GATE_BIT];
      end
      if (swAddr == HST_OFS_ADDR) begin
        addrReg <= swWdata[11:0];
      end
      if (swAddr == HST_OFS_DATA) begin
        dataReg <= swWdata;
      end
      if (swAddr == HST_OFS_MASK) begin
        maskReg <= swWdata[HST_STAT_W-1:0];
      end
    end
  end

  // ****************************************
  // Watchdog access
  // ****************************************
  // Access with the peripheral clock off is refused, not issued
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busWrReg <= 1'b0;
      busRdReg <= 1'b0;
      busAddrReg <= 12'h0;
      busWdataReg <= 32'h0;
    end else begin
      busWrReg <= goWr && gateReg && swWdata[HST_GO_WRITE_BIT];
      busRdReg <= goWr && gateReg && !swWdata[HST_GO_WRITE_BIT];
      if (goWr) begin
        busAddrReg <= addrReg;
        busWdataReg <= dataReg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdPendReg <= 1'b0;
      resultReg <= 32'h0;
    end else begin
      rdPendReg <= busRdReg;
      if (rdPendReg) begin
        resultReg <= link.regRdata;
      end
    end
  end

  // ****************************************
  // Events and interrupt
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nmiPrevReg <= 1'b0;
      rstPrevReg <= 1'b0;
      nmiReg <= 1'b0;
      sysRstReg <= 1'b0;
    end else begin
      nmiPrevReg <= link.nmiReq;
      rstPrevReg <= link.sysResetReq;
      nmiReg <= link.nmiReq;
      sysRstReg <= link.sysResetReq;
    end
  end

  assign events[HST_STAT_NMI] = link.nmiReq && !nmiPrevReg;
  assign events[HST_STAT_RST] = link.sysResetReq && !rstPrevReg;
  assign events[HST_STAT_REFUSED] = goWr && !gateReg;
  assign clrBits = (swWr && swAddr == HST_OFS_STAT) ? swWdata[HST_STAT_W-1:0] : 3'h0;

  // Set beats write-one-to-clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      statReg <= HST_STAT_RST_VAL;
    end else begin
      statReg <= (statReg & ~clrBits) | events;
    end
  end

  // ****************************************
  // Software read data
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      swRdataReg <= 32'h0;
    end else if (swRd) begin
      unique case (swAddr)
        HST_OFS_GATE: swRdataReg <= 32'(gateReg);
        HST_OFS_ADDR: swRdataReg <= 32'(addrReg);
        HST_OFS_DATA: swRdataReg <= dataReg;
        HST_OFS_RESULT: swRdataReg <= resultReg;
        HST_OFS_STAT: swRdataReg <= 32'(statReg);
        HST_OFS_MASK: swRdataReg <= 32'(maskReg);
        default: swRdataReg <= 32'h0;
      endcase
    end else begin
      swRdataReg <= 32'h0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.regAddr = busAddrReg;
  assign link.regWdata = busWdataReg;
  assign link.regWr = busWrReg;
  assign link.regRd = busRdReg;
  assign link.periphClkEn = gateReg;
  assign swRdata = swRdataReg;
  assign irq = |(statReg & maskReg);
  assign coreNmi = nmiReg;
  assign sysResetOut = sysRstReg;

endmodule : tswt_host
`default_nettype wire

// ===== logic/tswt_host_note_placeholder_none.sv
`default_nettype none
`default_nettype wire

// ===== logic/tswt_link_if.sv
`default_nettype none
interface tswt_link_if;
  logic [11:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic periphClkEn;
  logic nmiReq;
  logic sysResetReq;

  modport device (
    input regAddr, regWdata, regWr, regRd, periphClkEn,
    output regRdata, nmiReq, sysResetReq
  );
  modport host (
    output regAddr, regWdata, regWr, regRd, periphClkEn,
    input regRdata, nmiReq, sysResetReq
  );
endinterface : tswt_link_if
`default_nettype wire

// ===== logic/tswt_pkg.sv
`default_nettype none
package tswt_pkg;
  // ****************************************
  // Watchdog register map
  // ****************************************
  localparam int WDT_CNT_W = 32;
  localparam int WDT_ADDR_W = 12;
  localparam logic [11:0] WDT_OFS_LOAD = 12'h000;
  localparam logic [11:0] WDT_OFS_VALUE = 12'h004;
  localparam logic [11:0] WDT_OFS_CTL = 12'h008;
  localparam logic [11:0] WDT_OFS_ICR = 12'h00c;
  localparam logic [11:0] WDT_OFS_RIS = 12'h010;
  localparam logic [11:0] WDT_OFS_MIS = 12'h014;
  localparam logic [11:0] WDT_OFS_LOCK = 12'hc00;
  localparam logic [31:0] WDT_UNLOCK_KEY = 32'h1acce551;
  localparam logic [31:0] WDT_LOAD_RST = 32'hffffffff;
  localparam logic WDT_CTL_RST = 1'h0;
  localparam logic WDT_RIS_RST = 1'h0;
  localparam logic WDT_LOCK_RST = 1'h0;
  localparam int WDT_CTL_INTERRUPT_ENABLE_BIT_BIT = 0;
  localparam int WDT_CTL_RESET_OUTPUT_ENABLE_BIT = 1;
  localparam int WDT_RIS_BIT = 0;
  localparam int WDT_LOCK_BIT = 0;

  // ****************************************
  // Controller register map
  // ****************************************
  localparam int HST_ADDR_W = 5;
  localparam logic [4:0] HST_OFS_GATE = 5'h00;
  localparam logic [4:0] HST_OFS_ADDR = 5'h04;
  localparam logic [4:0] HST_OFS_DATA = 5'h08;
  localparam logic [4:0] HST_OFS_GO = 5'h0c;
  localparam logic [4:0] HST_OFS_RESULT = 5'h10;
  localparam logic [4:0] HST_OFS_STAT = 5'h14;
  localparam logic [4:0] HST_OFS_MASK = 5'h18;
  localparam int HST_GATE_BIT = 0;
  localparam int HST_GO_WRITE_BIT = 0;
  localparam int HST_STAT_W = 3;
  localparam int HST_STAT_NMI = 0;
  localparam int HST_STAT_RST = 1;
  localparam int HST_STAT_REFUSED = 2;
  localparam logic [2:0] HST_STAT_RST_VAL = 3'h0;
endpackage : tswt_pkg
`default_nettype wire

// ===== testbench/tswt_link_sva.sv
`default_nettype none
module tswt_link_sva
  import tswt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link signals
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic periphClkEn,
  input wire logic nmiReq,
  input wire logic sysResetReq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Shadow of lock and enable
  // ****
  logic lockedReg;
  logic intEnReg;
  logic wrOpen;
  assign wrOpen = regWr && !lockedReg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lockedReg <= 1'b0;
    end else if (regWr && regAddr == WDT_OFS_LOCK) begin
      lockedReg <= regWdata != WDT_UNLOCK_KEY;
    end
  end
  // Enable only falls with reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intEnReg <= 1'b0;
    end else if (wrOpen && regAddr == WDT_OFS_CTL && regWdata[WDT_CTL_INTERRUPT_ENABLE_BIT_BIT]) begin
      intEnReg <= 1'b1;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_lock_read: assert property (regRd && regAddr == WDT_OFS_LOCK |=>
    regRdata[0] == lockedReg) else $error("lock readback wrong");
  a_ctl_frozen: assert property (regRd && regAddr == WDT_OFS_CTL && intEnReg |=>
    regRdata[0]) else $error("enable bit lost");
  a_nmi_needs_en: assert property (nmiReq |-> intEnReg)
    else $error("nmi without enable");
  a_rst_needs_en: assert property (sysResetReq |-> intEnReg)
    else $error("reset without enable");
  a_rst_sticky: assert property (sysResetReq |=> sysResetReq)
    else $error("reset dropped");
  a_rst_cause: assert property ($rose(sysResetReq) |-> $past(nmiReq))
    else $error("reset without pending nmi");
  a_load_keeps: assert property (regWr && regAddr == WDT_OFS_LOAD && nmiReq |=> nmiReq)
    else $error("load write cleared nmi");
  a_icr_clears: assert property (wrOpen && regAddr == WDT_OFS_ICR |=> !nmiReq)
    else $error("clear ignored");
  a_locked_icr: assert property (regWr && lockedReg && regAddr == WDT_OFS_ICR && nmiReq
    |=> nmiReq) else $error("locked clear took effect");
  a_zero_irq: assert property (wrOpen && regAddr == WDT_OFS_LOAD && regWdata == 32'h0
    && intEnReg |=> nmiReq) else $error("zero load no nmi");
endmodule : tswt_link_sva
`default_nettype wire

// ===== testbench/tswt_tb.sv
`default_nettype none
module tswt_tb
  import tswt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] swAddr = 5'h00;
  logic [31:0] swWdata = 32'h0;
  logic swWr = 1'b0;
  logic swRd = 1'b0;
  logic [31:0] swRdata;
  logic [31:0] countValue;
  logic irq, coreNmi, sysResetOut, timeoutPulse;
  logic [31:0] rd;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  tswt_link_if link ();
  tswt_device tswt_device_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link),
    .countValue(countValue), .timeoutPulse(timeoutPulse));
  tswt_host tswt_host_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .irq(irq),
    .coreNmi(coreNmi), .sysResetOut(sysResetOut));
  tswt_link_sva tswt_link_sva_inst (.mclk(mclk), .sys_rst(sys_rst), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWr(link.regWr), .regRd(link.regRd),
    .regRdata(link.regRdata), .periphClkEn(link.periphClkEn), .nmiReq(link.nmiReq),
    .sysResetReq(link.sysResetReq));
  always #10 mclk = ~mclk;
  // ****
  // Bus and check tasks
  // ****
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic swW(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge mclk);
    swWr <= 1'b0;
  endtask : swW
  task automatic swR(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge mclk);
    swRd <= 1'b0;
    @(negedge mclk);
    d = swRdata;
  endtask : swR
  task automatic wdW(input logic [11:0] a, input logic [31:0] d);
    swW(HST_OFS_ADDR, {20'h0, a});
    swW(HST_OFS_DATA, d);
    swW(HST_OFS_GO, 32'h1);
  endtask : wdW
  // Spare idle cycles so the result register has settled
  task automatic wdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
    swW(HST_OFS_ADDR, {20'h0, a});
    swW(HST_OFS_GO, 32'h0);
    repeat (4) @(posedge mclk);
    swR(HST_OFS_RESULT, rd);
    chk(what, exp, rd);
  endtask : wdChk
  task automatic waitTo();
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (timeoutPulse !== 1'b1 && n < 400);
  endtask : waitTo
  task automatic doReset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    swW(HST_OFS_GATE, 32'h1);
  endtask : doReset
  // ****
  // Scenarios
  // ****
  task automatic testHost();
    chk("cnt rst", WDT_LOAD_RST, countValue);
    swW(HST_OFS_GO, 32'h1);
    swR(HST_OFS_STAT, rd);
    chk("refused", 32'h4, rd);
    swW(HST_OFS_MASK, 32'h4);
    @(negedge mclk);
    chk("irq set", 32'h1, {31'h0, irq});
    swW(HST_OFS_STAT, 32'h4);
    @(negedge mclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    swW(HST_OFS_GATE, 32'h1);
    wdChk("load rst", WDT_OFS_LOAD, WDT_LOAD_RST);
    wdChk("ctl rst", WDT_OFS_CTL, 32'h0);
    wdChk("unmapped", 12'h020, 32'h0);
  endtask : testHost
  task automatic testTwoStage();
    wdW(WDT_OFS_LOAD, 32'h14);
    wdW(WDT_OFS_CTL, 32'h2);
    wdW(WDT_OFS_CTL, 32'h3);
    waitTo();
    chk("first", 32'h1, {31'h0, timeoutPulse});
    chk("reload", 32'h14, countValue);
    waitTo();
    chk("period", 32'h15, n);
    @(negedge mclk);
    @(negedge mclk);
    chk("nmi", 32'h1, {31'h0, coreNmi});
    chk("sysreset", 32'h1, {31'h0, sysResetOut});
    swR(HST_OFS_STAT, rd);
    chk("stat", 32'h3, rd);
  endtask : testTwoStage
  task automatic testClear();
    doReset();
    wdW(WDT_OFS_LOAD, 32'h1e);
    wdW(WDT_OFS_CTL, 32'h3);
    waitTo();
    wdW(WDT_OFS_LOAD, 32'h28);
    @(negedge mclk);
    @(negedge mclk);
    chk("newload", 32'h28, countValue);
    wdChk("ris kept", WDT_OFS_RIS, 32'h1);
    wdW(WDT_OFS_ICR, 32'h0);
    @(negedge mclk);
    @(negedge mclk);
    chk("icr reload", 32'h28, countValue);
    wdChk("ris clr", WDT_OFS_RIS, 32'h0);
    chk("nmi clr", 32'h0, {31'h0, coreNmi});
    wdW(WDT_OFS_CTL, 32'h0);
    wdChk("ctl frozen", WDT_OFS_CTL, 32'h3);
    waitTo();
    chk("resumed", 32'h1, {31'h0, timeoutPulse});
    chk("no reset", 32'h0, {31'h0, sysResetOut});
    swW(HST_OFS_GATE, 32'h0);
    @(negedge mclk);
    rd = countValue;
    repeat (5) @(negedge mclk);
    chk("gated", rd, countValue);
    swW(HST_OFS_GATE, 32'h1);
    wdW(WDT_OFS_ICR, 32'h0);
  endtask : testClear
  task automatic testLock();
    wdW(WDT_OFS_LOCK, 32'h5);
    wdChk("locked", WDT_OFS_LOCK, 32'h1);
    wdW(WDT_OFS_LOAD, 32'h7);
    wdChk("load held", WDT_OFS_LOAD, 32'h28);
    waitTo();
    wdW(WDT_OFS_ICR, 32'h0);
    wdChk("icr locked", WDT_OFS_RIS, 32'h1);
    wdW(WDT_OFS_LOCK, WDT_UNLOCK_KEY);
    wdChk("unlocked", WDT_OFS_LOCK, 32'h0);
    wdW(WDT_OFS_ICR, 32'h0);
    wdChk("icr open", WDT_OFS_RIS, 32'h0);
    wdW(WDT_OFS_LOAD, 32'h0);
    repeat (3) @(negedge mclk);
    chk("zero load", 32'h1, {31'h0, coreNmi});
  endtask : testLock
  // ****
  // Main sequence and watchdog of the run
  // ****
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    testHost();
    testTwoStage();
    testClear();
    testLock();
    end_of_test();
  end
endmodule : tswt_tb
`default_nettype wire
